// [common/jcfg_regs.vh]
// constants for the test-port configuration controller
`ifndef JCFG_REGS_VH
`define JCFG_REGS_VH

// instruction register width and opcodes (opcode values are arbitrary)
`define JCFG_IR_W 10
`define JCFG_OP_BYPASS 10'h3ff
`define JCFG_OP_IDCODE 10'h006
`define JCFG_OP_SAMPLE 10'h005
`define JCFG_OP_PROGRAM 10'h002
`define JCFG_OP_DISENGAGE 10'h2d0
`define JCFG_OP_IO_SETUP 10'h00d
`define JCFG_OP_ENGAGE 10'h2b0

// data register widths
`define JCFG_DR_W 32

// defaults for stream length and initialisation clocks
`define JCFG_STREAM_BITS 16'h0040
`define JCFG_INIT_CYCLES 16'h0010

// identification word, value arbitrary
`define JCFG_IDCODE_VAL 32'h0a5a5001

`endif

// [logic/jcfg_port.v]
// test-port configuration controller: tap, bypass, id, sample and stream loader
`timescale 1ns/10ps
`include "jcfg_regs.vh"
//
// Functional notes
// [R1] untargeted device passes data through one bypass bit
// [R2] done flag high only after successful load
// [R3] host reads done flag to judge success
// [R4] host clocks extra cycles after stream
// [R5] bypass, idcode, sample leave configuration untouched
// [R6] host disengages then io-setup before other instructions
// [R7] io-setup configures buffers, interrupts after disengage
// [R8] host issues disengage before io-setup
// [R9] disengage idles the active-scheme controllers
// [R10] engage returns disengaged controller to operation
// [R11] global clear and oe never touch test port
// [R12] host keeps chain enable low while loading
// [R13] chain members grounded or loaded in order
// [R14] chain-enable output may be unconnected user io
// [R15] host keeps reconfiguration request high while loading
// [R16] tdo changes on falling edge, tri-stated otherwise
// [R17] tdi and tms sampled on rising edge
// [R18] test-port loading aborts other configuration schemes
// [R19] count of initialisation clocks is host parameter
module jcfg_port #(
	parameter STREAM_BITS = `JCFG_STREAM_BITS,
	parameter INIT_CYCLES = `JCFG_INIT_CYCLES,
	parameter IDCODE = `JCFG_IDCODE_VAL
) (
	input wire clk,
	input wire nrst,
	input wire tck,
	input wire tms,
	input wire tdi,
	input wire chain_enable_low,
	input wire reconfig_low,
	input wire [2:0] scheme_select,
	input wire global_clear_low,
	input wire global_output_enable,
	input wire other_cfg_busy,
	input wire [31:0] user_pins,
	output reg tdo,
	output reg tdo_oe,
	output wire config_done_flag,
	output wire chain_enable_out_low,
	output reg active_ctrl_idle,
	output reg io_setup_mode,
	output reg other_cfg_abort,
	output wire user_reset_low,
	output wire user_output_enable
);

// ----------------------------------------
// tap states
// ----------------------------------------
localparam [3:0] S_RESET = 4'h0, S_IDLE = 4'h1, S_SEL_DR = 4'h2, S_CAP_DR = 4'h3;
localparam [3:0] S_SH_DR = 4'h4, S_EX1_DR = 4'h5, S_PA_DR = 4'h6, S_EX2_DR = 4'h7;
localparam [3:0] S_UP_DR = 4'h8, S_SEL_IR = 4'h9, S_CAP_IR = 4'ha, S_SH_IR = 4'hb;
localparam [3:0] S_EX1_IR = 4'hc, S_PA_IR = 4'hd, S_EX2_IR = 4'he, S_UP_IR = 4'hf;

localparam [1:0] C_EMPTY = 2'h0, C_LOAD = 2'h1, C_INIT = 2'h2, C_DONE = 2'h3;

// ----------------------------------------
// pin synchronisers and tck edges
// ----------------------------------------
reg [1:0] tck_s;
reg tck_d;
reg [1:0] tms_s;
reg [1:0] tdi_s;
reg [1:0] nce_s;
reg [1:0] ncfg_s;
reg [1:0] busy_s;
reg [31:0] pins_s1;
reg [31:0] pins_s2;
wire tck_rise = tck_s[1] & ~tck_d;
wire tck_fall = ~tck_s[1] & tck_d;

always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		tck_s <= 2'h0;
		tck_d <= 1'b0;
		tms_s <= 2'h3;
		tdi_s <= 2'h3;
		nce_s <= 2'h3;
		ncfg_s <= 2'h3;
		busy_s <= 2'h0;
		pins_s1 <= 32'h0;
		pins_s2 <= 32'h0;
	end else begin
		tck_s <= {tck_s[0], tck};
		tck_d <= tck_s[1];
		tms_s <= {tms_s[0], tms};
		tdi_s <= {tdi_s[0], tdi};
		nce_s <= {nce_s[0], chain_enable_low};
		ncfg_s <= {ncfg_s[0], reconfig_low};
		busy_s <= {busy_s[0], other_cfg_busy};
		pins_s1 <= user_pins;
		pins_s2 <= pins_s1;
	end
end

wire tms_q = tms_s[1];
wire tdi_q = tdi_s[1];

// ----------------------------------------
// tap controller
// ----------------------------------------
reg [3:0] tap;
reg [3:0] next_tap;

always @* begin
	case (tap)
	S_RESET: next_tap = tms_q ? S_RESET : S_IDLE;
	S_IDLE: next_tap = tms_q ? S_SEL_DR : S_IDLE;
	S_SEL_DR: next_tap = tms_q ? S_SEL_IR : S_CAP_DR;
	S_CAP_DR: next_tap = tms_q ? S_EX1_DR : S_SH_DR;
	S_SH_DR: next_tap = tms_q ? S_EX1_DR : S_SH_DR;
	S_EX1_DR: next_tap = tms_q ? S_UP_DR : S_PA_DR;
	S_PA_DR: next_tap = tms_q ? S_EX2_DR : S_PA_DR;
	S_EX2_DR: next_tap = tms_q ? S_UP_DR : S_SH_DR;
	S_UP_DR: next_tap = tms_q ? S_SEL_DR : S_IDLE;
	S_SEL_IR: next_tap = tms_q ? S_RESET : S_CAP_IR;
	S_CAP_IR: next_tap = tms_q ? S_EX1_IR : S_SH_IR;
	S_SH_IR: next_tap = tms_q ? S_EX1_IR : S_SH_IR;
	S_EX1_IR: next_tap = tms_q ? S_UP_IR : S_PA_IR;
	S_PA_IR: next_tap = tms_q ? S_EX2_IR : S_PA_IR;
	S_EX2_IR: next_tap = tms_q ? S_UP_IR : S_SH_IR;
	S_UP_IR: next_tap = tms_q ? S_SEL_DR : S_IDLE;
	default: next_tap = S_RESET;
	endcase
end

// ----------------------------------------
// instruction, data and bypass registers
// ----------------------------------------
reg [`JCFG_IR_W-1:0] ir_sr;
reg [`JCFG_IR_W-1:0] ir;
reg [`JCFG_DR_W-1:0] dr_sr;
reg byp;
wire long_dr = (ir == `JCFG_OP_IDCODE) || (ir == `JCFG_OP_SAMPLE);
wire new_prog = (ir_sr == `JCFG_OP_PROGRAM);
wire new_io = (ir_sr == `JCFG_OP_IO_SETUP);
// an update-IR that restarts or interrupts the load must not also finish it
wire ir_restart = (tap == S_UP_IR) && (new_prog || (new_io && active_ctrl_idle));

// ----------------------------------------
// configuration progress
// ----------------------------------------
reg [1:0] cfg;
reg [15:0] cnt;
wire cfg_busy = (cfg == C_LOAD) || (cfg == C_INIT);
// a board fault mid-load (chain enable high, reconfiguration asserted) drops the image
wire board_bad = nce_s[1] | ~ncfg_s[1];

always @(posedge clk or negedge nrst) begin
	if (!nrst) begin
		tap <= S_RESET;
		ir_sr <= `JCFG_OP_IDCODE;
		ir <= `JCFG_OP_IDCODE;
		dr_sr <= 32'h0;
		byp <= 1'b0;
		tdo <= 1'b0;
		tdo_oe <= 1'b0;
		cfg <= C_EMPTY;
		cnt <= 16'h0;
		active_ctrl_idle <= 1'b0;
		io_setup_mode <= 1'b0;
		other_cfg_abort <= 1'b0;
	end else begin
		other_cfg_abort <= 1'b0;
		if (cfg_busy && board_bad) begin
			cfg <= C_EMPTY; // [R2]
		end
		if (tck_rise) begin
			tap <= next_tap; // [R17]
			case (tap)
			S_RESET: begin
				ir <= `JCFG_OP_IDCODE;
				io_setup_mode <= 1'b0;
			end
			S_CAP_IR: ir_sr <= {{(`JCFG_IR_W-2){1'b0}}, 2'h1};
			S_SH_IR: ir_sr <= {tdi_q, ir_sr[`JCFG_IR_W-1:1]}; // [R17]
			S_UP_IR: begin
				ir <= ir_sr;
				if (new_prog) begin
					cfg <= C_LOAD; // [R18]
					cnt <= 16'h0;
					other_cfg_abort <= busy_s[1]; // [R18]
				end
				if (ir_sr == `JCFG_OP_DISENGAGE) begin
					active_ctrl_idle <= 1'b1; // [R9]
				end
				if (ir_sr == `JCFG_OP_ENGAGE) begin
					active_ctrl_idle <= 1'b0; // [R10]
				end
				io_setup_mode <= new_io; // [R7]
				if (new_io && active_ctrl_idle && cfg_busy) begin
					cfg <= C_EMPTY; // [R7]
				end
			end
			S_CAP_DR: begin
				byp <= 1'b0;
				if (ir == `JCFG_OP_IDCODE) begin
					dr_sr <= IDCODE; // [R5]
				end else if (ir == `JCFG_OP_SAMPLE) begin
					dr_sr <= pins_s2; // [R5]
				end
			end
			S_SH_DR: begin
				byp <= tdi_q; // [R1]
				dr_sr <= {tdi_q, dr_sr[`JCFG_DR_W-1:1]};
				if (ir == `JCFG_OP_PROGRAM && cfg == C_LOAD && !board_bad) begin
					if (cnt == STREAM_BITS - 16'h1) begin
						cfg <= C_INIT;
						cnt <= 16'h0;
					end else begin
						cnt <= cnt + 16'h1;
					end
				end
			end
			default: begin
			end
			endcase
			// extra clocks after the stream finish initialisation, in any tap state
			if (cfg == C_INIT && !board_bad && !ir_restart) begin // [R7]
				if (cnt == INIT_CYCLES - 16'h1) begin
					cfg <= C_DONE; // [R2]
				end else begin
					cnt <= cnt + 16'h1;
				end
			end
		end
		if (tck_fall) begin
			tdo_oe <= (tap == S_SH_IR) || (tap == S_SH_DR); // [R16]
			if (tap == S_SH_IR) begin
				tdo <= ir_sr[0]; // [R16]
			end else if (tap == S_SH_DR) begin
				tdo <= long_dr ? dr_sr[0] : byp; // [R1]
			end
		end
	end
end

// ----------------------------------------
// status and user-side outputs
// ----------------------------------------
assign config_done_flag = (cfg == C_DONE); // [R2]
// chain-enable output goes low with the done flag while chain enable is low; free to float when unused downstream
assign chain_enable_out_low = ~(config_done_flag & ~nce_s[1]); // [R14]
// global clear and oe only gate user logic, never the tap path
assign user_reset_low = global_clear_low & config_done_flag; // [R11]
assign user_output_enable = global_output_enable & config_done_flag & ~io_setup_mode &
	(scheme_select != 3'h7); // [R11]

endmodule

// [bench/jcfg_props.sv]
// concurrent checks on the configuration port pins
`timescale 1ns/10ps
module jcfg_props (
	input wire clk,
	input wire nrst,
	input wire tck,
	input wire chain_enable_low,
	input wire global_clear_low,
	input wire tdo,
	input wire tdo_oe,
	input wire config_done_flag,
	input wire chain_enable_out_low,
	input wire active_ctrl_idle,
	input wire io_setup_mode,
	input wire other_cfg_abort,
	input wire user_reset_low
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// --
	// registered outputs move only on the tck phase that owns them; user_reset_low and chain_enable_out_low match their equations
	// --
	a_tdo_on_fall: assert property ($changed(tdo) |-> !tck) else $error("tdo off phase");
	a_oe_on_fall: assert property ($changed(tdo_oe) |-> !tck) else $error("oe off phase");
	a_done_rise: assert property ($rose(config_done_flag) |-> tck && !chain_enable_low)
		else $error("done rose badly");
	a_clear_gate: assert property (user_reset_low == (global_clear_low && config_done_flag))
		else $error("clear gate wrong");
	a_chain_out: assert property (chain_enable_out_low == !(config_done_flag && !chain_enable_low))
		else $error("chain out wrong");
	a_idle_update: assert property ($changed(active_ctrl_idle) |-> tck) else $error("idle moved");
	a_io_update: assert property ($changed(io_setup_mode) |-> tck) else $error("io mode moved");
	a_abort_pulse: assert property (other_cfg_abort |-> tck ##1 !other_cfg_abort)
		else $error("abort not a pulse");
	c_done: cover property ($rose(config_done_flag));
	c_idle: cover property ($rose(active_ctrl_idle));
	c_abort: cover property (other_cfg_abort);
endmodule

// [bench/jcfg_host.sv]
// test-port host model: one tck period per call
`timescale 1ns/10ps
module jcfg_host (
	input wire clk,
	output reg tck,
	output reg tms,
	output reg tdi
);
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end
	// tck rests low between calls; eight clk per period keeps both phases above three clk
	// callers enter on a falling clk edge; tms and tdi move together with tck's fall
	task step(input logic m, input logic d);
		begin
			tms = m;
			tdi = d;
			repeat (4) @(negedge clk);
			tck = 1'b1;
			repeat (4) @(negedge clk);
			tck = 1'b0;
		end
	endtask
endmodule

// [bench/tb.sv]
// bench: host sequences, pin scoreboard and verdict
`timescale 1ns/10ps
`include "jcfg_regs.vh"
module tb;
	localparam SB = 16'h0004;
	localparam IC = 16'h0028;
	reg clk = 1'b0;
	reg nrst = 1'b0;
	reg cel = 1'b0;
	reg ncfg = 1'b1;
	reg gcl = 1'b1;
	reg goe = 1'b1;
	reg [2:0] sel = 3'h0;
	reg busy = 1'b0;
	reg [31:0] pins = 32'h0;
	reg [31:0] r;
	wire tck, tms, tdi, tdo, oe, done, ceo, idle, ios, abort, urst, uoe;
	int n_fail = 0;
	int n_compared = 0;
	int n_abort = 0;
	logic q[$];
	always #50 clk = ~clk;
	jcfg_host host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi));
	jcfg_port #(.STREAM_BITS(SB), .INIT_CYCLES(IC)) dut (.clk(clk), .nrst(nrst), .tck(tck),
		.tms(tms), .tdi(tdi), .chain_enable_low(cel), .reconfig_low(ncfg), .scheme_select(sel),
		.global_clear_low(gcl), .global_output_enable(goe), .other_cfg_busy(busy),
		.user_pins(pins), .tdo(tdo), .tdo_oe(oe), .config_done_flag(done),
		.chain_enable_out_low(ceo), .active_ctrl_idle(idle), .io_setup_mode(ios),
		.other_cfg_abort(abort), .user_reset_low(urst), .user_output_enable(uoe));
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		begin
			n_compared++;
			if (seen !== exp) begin
				n_fail++;
				$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task stop_test;
		begin
			$display("compared %0d failed %0d", n_compared, n_fail);
			if (n_fail == 0 && n_compared > 0) begin
				$display("bench passed");
			end else begin
				$display("bench failed");
			end
			$finish;
		end
	endtask
	// from idle through shift and back to idle, noting each expected tdo bit
	task shift(input logic ir, input int n, input logic [31:0] din, input logic [31:0] dexp);
		int i;
		begin
			host.step(1'b1, 1'b1);
			if (ir) host.step(1'b1, 1'b1);
			host.step(1'b0, 1'b1);
			host.step(1'b0, 1'b1);
			for (i = 0; i < n; i++) begin
				q.push_back(dexp[i]);
				host.step(i == n - 1, din[i]);
			end
			host.step(1'b1, 1'b1);
			host.step(1'b0, 1'b1);
		end
	endtask
	always @(posedge tck) if (oe === 1'b1) begin
		if (q.size() == 0) chk(1'b1, 1'b0);
		else chk(tdo, q.pop_front());
	end
	// the abort is a one-clk pulse, so it is counted here and compared later
	always @(posedge clk) if (abort === 1'b1) n_abort++;
	initial begin
		#2000000;
		chk(1'b0, 1'b1);
		stop_test;
	end
	initial begin
		r = $urandom(32'ha3f1);
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		pins = $urandom;
		chk(done, 1'b0);
		host.step(1'b0, 1'b1);
		shift(1'b1, 10, `JCFG_OP_IDCODE, 32'h1);
		shift(1'b0, 32, 32'h0, `JCFG_IDCODE_VAL);
		r = $urandom;
		shift(1'b1, 10, `JCFG_OP_BYPASS, 32'h1);
		shift(1'b0, 32, r, {r[30:0], 1'b0});
		busy = 1'b1;
		shift(1'b1, 10, `JCFG_OP_PROGRAM, 32'h1);
		busy = 1'b0;
		chk(n_abort, 32'h1);
		shift(1'b0, SB, r, {r[30:0], 1'b0});
		chk(done, 1'b0);
		gcl = 1'b0;
		goe = 1'b0;
		// sample traffic doubles as the extra init clocks
		shift(1'b1, 10, `JCFG_OP_SAMPLE, 32'h1);
		shift(1'b0, 32, 32'h0, pins);
		gcl = 1'b1;
		goe = 1'b1;
		@(negedge clk);
		chk({done, urst, ceo, uoe}, 4'b1101);
		sel = 3'h7;
		@(negedge clk);
		chk(uoe, 1'b0);
		sel = 3'h0;
		shift(1'b1, 10, `JCFG_OP_PROGRAM, 32'h1);
		chk(n_abort, 32'h1);
		cel = 1'b1;
		shift(1'b0, SB, r, {r[30:0], 1'b0});
		repeat (IC) host.step(1'b0, 1'b1);
		chk(done, 1'b0);
		cel = 1'b0;
		shift(1'b1, 10, `JCFG_OP_DISENGAGE, 32'h1);
		chk(idle, 1'b1);
		shift(1'b1, 10, `JCFG_OP_IO_SETUP, 32'h1);
		chk(ios, 1'b1);
		shift(1'b1, 10, `JCFG_OP_ENGAGE, 32'h1);
		chk({idle, ios}, 2'b00);
		// io-setup after disengage interrupts a load still in its init clocks
		shift(1'b1, 10, `JCFG_OP_PROGRAM, 32'h1);
		shift(1'b0, SB, r, {r[30:0], 1'b0});
		shift(1'b1, 10, `JCFG_OP_DISENGAGE, 32'h1);
		shift(1'b1, 10, `JCFG_OP_IO_SETUP, 32'h1);
		chk({ios, uoe}, 2'b10);
		shift(1'b1, 10, `JCFG_OP_ENGAGE, 32'h1);
		repeat (IC) host.step(1'b0, 1'b1);
		chk({done, idle}, 2'b00);
		// a reconfiguration request during the load drops the image
		shift(1'b1, 10, `JCFG_OP_PROGRAM, 32'h1);
		ncfg = 1'b0;
		host.step(1'b0, 1'b1);
		ncfg = 1'b1;
		shift(1'b0, SB, r, {r[30:0], 1'b0});
		repeat (IC) host.step(1'b0, 1'b1);
		chk(done, 1'b0);
		stop_test;
	end
endmodule
bind jcfg_port jcfg_props u_props (.clk(clk), .nrst(nrst), .tck(tck),
	.chain_enable_low(chain_enable_low), .global_clear_low(global_clear_low), .tdo(tdo),
	.tdo_oe(tdo_oe), .config_done_flag(config_done_flag),
	.chain_enable_out_low(chain_enable_out_low), .active_ctrl_idle(active_ctrl_idle),
	.io_setup_mode(io_setup_mode), .other_cfg_abort(other_cfg_abort),
	.user_reset_low(user_reset_low));
